// ### verilog/clsd_pkg.sv
// constants, register map and states of the class-d pwm output stage
// Notes on behaviour
// - after reset all four channels stay powered down until software enables them
// - channel power-up starts only on a write to misc_control
// - ramp from zero to 50/50 square wave over 365 ms, and back down
// - ready output stays low while the channels ramp down, and while they ramp up in late mode
// - pwm_stage_control picks ready rising at ramp start or ramp end
// - each channel drives two outputs, one the inverse of the other
// - 384 kHz modulation, full scale duty limited to 97:3
// - mute pin acts only on the outputs selected in a register field
// - mute pin low ramps selected outputs gradually down to silence
// - by default the pin returning high ramps the outputs back up
// - in software mode outputs stay muted until the unmute bit is set
package clsd_pkg;
    localparam logic [15:0] MISC_CONTROL_OFS      = 16'h000A;
    localparam logic [15:0] PWM_STAGE_CONTROL_OFS = 16'h001F;

    // misc_control fields
    localparam int          MISC_EN_BIT   = 0;
    localparam int          MISC_BUSY_BIT = 1;
    localparam logic [15:0] MISC_RESET    = 16'h0000;

    // pwm_stage_control fields
    localparam int          STG_LATE_BIT   = 0;
    localparam int          STG_SWUNM_BIT  = 1;
    localparam int          STG_UNMUTE_BIT = 2;
    localparam int          STG_SEL_LSB    = 3;
    localparam int          STG_MUTED_BIT  = 7;
    localparam logic [15:0] STG_RESET      = 16'h0078;
    localparam logic [15:0] STG_WR_MASK    = 16'h007F;

    // timing
    localparam int unsigned CLK_HZ         = 50_000_000;
    localparam int unsigned PWM_HZ         = 384_000;
    localparam int unsigned PWM_PERIOD_CYC = CLK_HZ / PWM_HZ;
    localparam int unsigned DUTY_LO_PCT    = 3;
    localparam int unsigned DUTY_MIN_CYC   =
        (PWM_PERIOD_CYC * DUTY_LO_PCT + 99) / 100;
    localparam int unsigned DUTY_MAX_CYC   = PWM_PERIOD_CYC - DUTY_MIN_CYC;
    localparam int unsigned HALF_CYC       = PWM_PERIOD_CYC / 2;
    localparam int unsigned RAMP_MS        = 365;
    localparam int unsigned RAMP_CYC       = RAMP_MS * (CLK_HZ / 1000);
    localparam int unsigned MUTE_RAMP_MS   = 10;
    localparam int unsigned MUTE_RAMP_CYC  = MUTE_RAMP_MS * (CLK_HZ / 1000);
    localparam logic [6:0]  GAIN_FULL      = 7'h40;
    localparam logic [6:0]  GAIN_RESET     = 7'h40;

    typedef enum logic [1:0] {
        ST_OFF,
        ST_UP,
        ST_ON,
        ST_DOWN
    } clsd_state_e;
endpackage

// ### verilog/clsd_pwm_out.sv
// four channel class-d pwm output stage with anti-pop ramp and mute
`timescale 1ns/10ps
module clsd_pwm_out #(
    parameter int unsigned P_RAMP_CYC = clsd_pkg::RAMP_CYC,
    parameter int unsigned P_MUTE_CYC = clsd_pkg::MUTE_RAMP_CYC
) (
    input  wire logic               i_mclk,
    input  wire logic               i_rstn,
    input  wire logic               i_reg_wr,
    input  wire logic               i_reg_rd,
    input  wire logic [15:0]        i_reg_addr,
    input  wire logic [15:0]        i_reg_wdata,
    output logic      [15:0]        o_reg_rdata,
    input  wire logic               i_mute_n,
    input  wire logic signed [15:0] i_sample_1,
    input  wire logic signed [15:0] i_sample_2,
    input  wire logic signed [15:0] i_sample_3,
    input  wire logic signed [15:0] i_sample_4,
    output logic                    o_class_d_channel_1_p,
    output logic                    o_class_d_channel_1_n,
    output logic                    o_class_d_channel_2_p,
    output logic                    o_class_d_channel_2_n,
    output logic                    o_class_d_channel_3_p,
    output logic                    o_class_d_channel_3_n,
    output logic                    o_class_d_channel_4_p,
    output logic                    o_class_d_channel_4_n,
    output logic                    o_pwm_ready
);
    localparam int unsigned STEP_CYC  = P_RAMP_CYC / clsd_pkg::HALF_CYC;
    localparam int unsigned MSTEP_CYC = P_MUTE_CYC / 64;
    localparam logic [7:0] HALF  = 8'(clsd_pkg::HALF_CYC);
    localparam logic [7:0] PER   = 8'(clsd_pkg::PWM_PERIOD_CYC);
    localparam logic [7:0] DMIN  = 8'(clsd_pkg::DUTY_MIN_CYC);
    localparam logic [7:0] DMAX  = 8'(clsd_pkg::DUTY_MAX_CYC);

    clsd_pkg::clsd_state_e state;
    logic [15:0]       misc_control;
    logic [15:0]       pwm_stage_control;
    logic [31:0]       ramp_tmr;
    logic [7:0]        ramp_lvl;
    logic [7:0]        pwm_cnt;
    logic              mute_meta;
    logic              mute_sync;
    logic              muted;
    logic [6:0]        mute_gain;
    logic [31:0]       mute_tmr;
    logic              wr_misc;
    logic              wr_stage;
    logic              late;
    logic              sw_unmute;
    logic [3:0]        mute_sel;
    logic signed [15:0] samp [4];
    logic [7:0]        duty [4];
    logic              out_p [4];
    logic              out_n [4];

    // registers arrive as whole 16-bit words from the control port
    assign wr_misc  = i_reg_wr && (i_reg_addr == clsd_pkg::MISC_CONTROL_OFS);
    assign wr_stage = i_reg_wr &&
                      (i_reg_addr == clsd_pkg::PWM_STAGE_CONTROL_OFS);
    assign late      = pwm_stage_control[clsd_pkg::STG_LATE_BIT];
    assign sw_unmute = pwm_stage_control[clsd_pkg::STG_SWUNM_BIT];
    assign mute_sel  = pwm_stage_control[clsd_pkg::STG_SEL_LSB +: 4];

    always_ff @(posedge i_mclk) begin
        if (!i_rstn) begin
            misc_control      <= clsd_pkg::MISC_RESET;
            pwm_stage_control <= clsd_pkg::STG_RESET;
        end else begin
            if (wr_misc) begin
                misc_control <= i_reg_wdata & 16'h0001;
            end
            if (wr_stage) begin
                pwm_stage_control <= i_reg_wdata & clsd_pkg::STG_WR_MASK;
            end
        end
    end

    always_ff @(posedge i_mclk) begin
        if (!i_rstn) begin
            o_reg_rdata <= 16'h0000;
        end else if (i_reg_rd) begin
            if (i_reg_addr == clsd_pkg::MISC_CONTROL_OFS) begin
                o_reg_rdata <= misc_control;
                o_reg_rdata[clsd_pkg::MISC_BUSY_BIT] <=
                    (state == clsd_pkg::ST_UP) || (state == clsd_pkg::ST_DOWN);
            end else if (i_reg_addr == clsd_pkg::PWM_STAGE_CONTROL_OFS) begin
                o_reg_rdata <= pwm_stage_control;
                o_reg_rdata[clsd_pkg::STG_MUTED_BIT] <= muted;
            end else begin
                o_reg_rdata <= 16'h0000;
            end
        end
    end

    // power sequencer: only a misc_control write moves it out of off
    always_ff @(posedge i_mclk) begin
        if (!i_rstn) begin
            state    <= clsd_pkg::ST_OFF;
            ramp_lvl <= 8'h00;
            ramp_tmr <= 32'h0000_0000;
        end else begin
            unique case (state)
                clsd_pkg::ST_OFF: begin
                    ramp_tmr <= 32'h0000_0000;
                    if (wr_misc && i_reg_wdata[clsd_pkg::MISC_EN_BIT]) begin
                        state <= clsd_pkg::ST_UP;
                    end
                end
                clsd_pkg::ST_UP: begin
                    if (wr_misc && !i_reg_wdata[clsd_pkg::MISC_EN_BIT]) begin
                        state    <= clsd_pkg::ST_DOWN;
                        ramp_tmr <= 32'h0000_0000;
                    end else if (ramp_tmr == STEP_CYC - 1) begin
                        ramp_tmr <= 32'h0000_0000;
                        if (ramp_lvl == HALF) begin
                            state <= clsd_pkg::ST_ON;
                        end else begin
                            ramp_lvl <= ramp_lvl + 8'h01;
                        end
                    end else begin
                        ramp_tmr <= ramp_tmr + 32'h0000_0001;
                    end
                end
                clsd_pkg::ST_ON: begin
                    ramp_tmr <= 32'h0000_0000;
                    if (wr_misc && !i_reg_wdata[clsd_pkg::MISC_EN_BIT]) begin
                        state <= clsd_pkg::ST_DOWN;
                    end
                end
                clsd_pkg::ST_DOWN: begin
                    if (wr_misc && i_reg_wdata[clsd_pkg::MISC_EN_BIT]) begin
                        state    <= clsd_pkg::ST_UP;
                        ramp_tmr <= 32'h0000_0000;
                    end else if (ramp_tmr == STEP_CYC - 1) begin
                        ramp_tmr <= 32'h0000_0000;
                        if (ramp_lvl == 8'h00) begin
                            state <= clsd_pkg::ST_OFF;
                        end else begin
                            ramp_lvl <= ramp_lvl - 8'h01;
                        end
                    end else begin
                        ramp_tmr <= ramp_tmr + 32'h0000_0001;
                    end
                end
            endcase
        end
    end

    // early mode trades pop margin for a faster handoff to the power stage
    always_ff @(posedge i_mclk) begin
        if (!i_rstn) begin
            o_pwm_ready <= 1'b0;
        end else begin
            o_pwm_ready <= (state == clsd_pkg::ST_ON) ||
                           ((state == clsd_pkg::ST_UP) && !late);
        end
    end

    // mute pin is asynchronous
    always_ff @(posedge i_mclk) begin
        if (!i_rstn) begin
            mute_meta <= 1'b1;
            mute_sync <= 1'b1;
        end else begin
            mute_meta <= i_mute_n;
            mute_sync <= mute_meta;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (!i_rstn) begin
            muted <= 1'b0;
        end else if (!mute_sync) begin
            muted <= 1'b1;
        end else if (!sw_unmute ||
                     pwm_stage_control[clsd_pkg::STG_UNMUTE_BIT]) begin
            muted <= 1'b0;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (!i_rstn) begin
            mute_gain <= clsd_pkg::GAIN_RESET;
            mute_tmr  <= 32'h0000_0000;
        end else if (mute_tmr == MSTEP_CYC - 1) begin
            mute_tmr <= 32'h0000_0000;
            if (muted && mute_gain != 7'h00) begin
                mute_gain <= mute_gain - 7'h01;
            end else if (!muted && mute_gain != clsd_pkg::GAIN_FULL) begin
                mute_gain <= mute_gain + 7'h01;
            end
        end else begin
            mute_tmr <= mute_tmr + 32'h0000_0001;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (!i_rstn) begin
            pwm_cnt <= 8'h00;
        end else if (pwm_cnt == PER - 8'h01) begin
            pwm_cnt <= 8'h00;
        end else begin
            pwm_cnt <= pwm_cnt + 8'h01;
        end
    end

    assign samp[0] = i_sample_1;
    assign samp[1] = i_sample_2;
    assign samp[2] = i_sample_3;
    assign samp[3] = i_sample_4;

    for (genvar c = 0; c < 4; c++) begin : g_ch
        logic [6:0]         gain;
        logic signed [23:0] prod;
        logic signed [9:0]  lvl;
        assign gain = mute_sel[c] ? mute_gain : clsd_pkg::GAIN_FULL;
        assign prod = 24'(samp[c]) * 24'($signed({1'b0, gain}));
        // zero gain leaves the 50/50 centre, never a stopped output
        assign lvl  = 10'(signed'({2'b00, HALF})) + 10'(prod >>> 15);
        always_comb begin
            if (state != clsd_pkg::ST_ON) begin
                duty[c] = ramp_lvl;
            end else if (lvl < signed'({2'b00, DMIN})) begin
                duty[c] = DMIN;
            end else if (lvl > signed'({2'b00, DMAX})) begin
                duty[c] = DMAX;
            end else begin
                duty[c] = lvl[7:0];
            end
        end
        always_ff @(posedge i_mclk) begin
            if (!i_rstn) begin
                out_p[c] <= 1'b0;
                out_n[c] <= 1'b1;
            end else begin
                out_p[c] <= (pwm_cnt < duty[c]);
                out_n[c] <= !(pwm_cnt < duty[c]);
            end
        end
    end

    assign o_class_d_channel_1_p = out_p[0];
    assign o_class_d_channel_1_n = out_n[0];
    assign o_class_d_channel_2_p = out_p[1];
    assign o_class_d_channel_2_n = out_n[1];
    assign o_class_d_channel_3_p = out_p[2];
    assign o_class_d_channel_3_n = out_n[2];
    assign o_class_d_channel_4_p = out_p[3];
    assign o_class_d_channel_4_n = out_n[3];

    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_rstn);

    a_off_silent: assert property ((state == clsd_pkg::ST_OFF)[*2]
        |-> !o_class_d_channel_1_p && !o_class_d_channel_4_p)
        else $error("powered down channel is not silent");
    a_start_write: assert property ((state == clsd_pkg::ST_OFF &&
        !(wr_misc && i_reg_wdata[clsd_pkg::MISC_EN_BIT]))
        |=> state == clsd_pkg::ST_OFF)
        else $error("power-up started without an enable write");
    a_ramp_done: assert property ((state == clsd_pkg::ST_UP &&
        ramp_lvl == HALF && ramp_tmr == STEP_CYC - 1 && !wr_misc)
        |=> state == clsd_pkg::ST_ON)
        else $error("ramp-up did not finish at half duty");
    a_ready_down: assert property (state == clsd_pkg::ST_DOWN
        |=> !o_pwm_ready)
        else $error("ready high during power-down");
    a_ready_mode: assert property (state == clsd_pkg::ST_UP
        |=> o_pwm_ready == !$past(late))
        else $error("ready does not follow early/late mode");
    a_compl_pair: assert property (
        o_class_d_channel_2_p != o_class_d_channel_2_n)
        else $error("channel outputs not complementary");
    a_duty_limit: assert property (state == clsd_pkg::ST_ON
        |-> duty[0] >= DMIN && duty[0] <= DMAX)
        else $error("duty outside the 97:3 limit");
    a_sel_unmuted: assert property (!mute_sel[1]
        |-> g_ch[1].gain == clsd_pkg::GAIN_FULL)
        else $error("unselected channel affected by mute");
    a_mute_step: assert property ((muted && mute_gain != 7'h00 &&
        mute_tmr == MSTEP_CYC - 1)
        |=> mute_gain == $past(mute_gain) - 7'h01)
        else $error("mute ramp not stepping down");
    a_auto_unmute: assert property ((muted && mute_sync && !sw_unmute)
        |=> !muted)
        else $error("pin high did not release mute");
    a_sw_hold: assert property ((muted && sw_unmute &&
        !pwm_stage_control[clsd_pkg::STG_UNMUTE_BIT]) |=> muted)
        else $error("released mute without the unmute bit");
    a_mute_centre: assert property ((state == clsd_pkg::ST_ON &&
        mute_sel[0] && mute_gain == 7'h00) |-> duty[0] == HALF)
        else $error("muted channel left the 50/50 centre");

    c_ramp_on: cover property (state == clsd_pkg::ST_UP
        ##1 state == clsd_pkg::ST_ON);
    c_ramp_off: cover property (state == clsd_pkg::ST_DOWN
        ##1 state == clsd_pkg::ST_OFF);
    c_mute_cycle: cover property (muted ##1 !muted);
    c_sw_unmute: cover property (sw_unmute && muted && mute_sync);
endmodule

// ### verification/clsd_amp_model.sv
// behavioural class-d power stage: per-channel duty meter and pair guard
`timescale 1ns/10ps
module clsd_amp_model #(
    parameter int P_PERIOD = 130
) (
    input  wire logic       i_mclk,
    input  wire logic       i_rstn,
    input  wire logic [3:0] i_p,
    input  wire logic [3:0] i_n,
    output logic      [7:0] o_duty [4],
    output logic            o_pair_bad
);
    int frame;
    int acc [4];

    initial begin
        frame = 0;
        o_pair_bad = 1'b0;
        for (int k = 0; k < 4; k++) begin
            acc[k] = 0;
            o_duty[k] = 8'h00;
        end
    end

    // a bridge shoots through if both legs conduct together
    always @(posedge i_mclk) begin
        if (i_rstn && ((i_p ^ i_n) !== 4'hF))
            o_pair_bad <= 1'b1;
        frame = (frame == P_PERIOD - 1) ? 0 : frame + 1;
        for (int k = 0; k < 4; k++) begin
            acc[k] = acc[k] + int'(i_p[k]);
            if (frame == 0) begin
                o_duty[k] <= 8'(acc[k]);
                acc[k] = 0;
            end
        end
    end
endmodule

// ### verification/tb_top.sv
// self-checking bench for the class-d pwm output stage
`timescale 1ns/10ps
module tb_top;
    localparam logic [15:0] CORNER [4] =
        '{16'h7FFF, 16'h8000, 16'h0000, 16'h4000};
    logic               mclk;
    logic               rstn;
    logic               wr;
    logic               rd;
    logic               mute_n;
    logic        [15:0] addr;
    logic        [15:0] wdata;
    logic        [15:0] rdata;
    logic        [15:0] v;
    logic signed [15:0] smp [4];
    wire         [3:0]  pp;
    wire         [3:0]  nn;
    wire                rdy;
    logic        [7:0]  duty [4];
    logic               bad;
    logic               prev;
    int                 num_errors;
    int                 comparisons;
    int                 edges;

    clsd_pwm_out #(.P_RAMP_CYC(650), .P_MUTE_CYC(640)) i_clsd_pwm_out (
        .i_mclk(mclk), .i_rstn(rstn), .i_reg_wr(wr), .i_reg_rd(rd),
        .i_reg_addr(addr), .i_reg_wdata(wdata), .o_reg_rdata(rdata),
        .i_mute_n(mute_n), .i_sample_1(smp[0]), .i_sample_2(smp[1]),
        .i_sample_3(smp[2]), .i_sample_4(smp[3]),
        .o_class_d_channel_1_p(pp[0]), .o_class_d_channel_1_n(nn[0]),
        .o_class_d_channel_2_p(pp[1]), .o_class_d_channel_2_n(nn[1]),
        .o_class_d_channel_3_p(pp[2]), .o_class_d_channel_3_n(nn[2]),
        .o_class_d_channel_4_p(pp[3]), .o_class_d_channel_4_n(nn[3]),
        .o_pwm_ready(rdy));

    clsd_amp_model i_clsd_amp_model (
        .i_mclk(mclk), .i_rstn(rstn), .i_p(pp), .i_n(nn),
        .o_duty(duty), .o_pair_bad(bad));

    task automatic chk(input string nm, input logic [15:0] seen,
                       input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask

    task automatic wr_reg(input logic [15:0] a, input logic [15:0] d);
        @(posedge mclk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge mclk);
        wr <= 1'b0;
    endtask

    task automatic rd_reg(input logic [15:0] a, output logic [15:0] d);
        @(posedge mclk);
        rd <= 1'b1;
        addr <= a;
        @(posedge mclk);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask

    task automatic set_all(input logic [15:0] s);
        @(posedge mclk);
        for (int k = 0; k < 4; k++)
            smp[k] <= s;
    endtask

    // audio scaled by full gain around mid-scale, held inside the 97:3 limits
    function automatic logic [15:0] exp_duty(input logic signed [15:0] s);
        int d;
        d = (int'(s) * int'(clsd_pkg::GAIN_FULL)) >>> 15;
        d = d + int'(clsd_pkg::HALF_CYC);
        if (d < int'(clsd_pkg::DUTY_MIN_CYC))
            d = int'(clsd_pkg::DUTY_MIN_CYC);
        if (d > int'(clsd_pkg::DUTY_MAX_CYC))
            d = int'(clsd_pkg::DUTY_MAX_CYC);
        return 16'(d);
    endfunction

    task automatic tally_and_finish();
        $display("comparisons %0d num_errors %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end

    // the whole sequence needs about 11k cycles
    initial begin
        repeat (60000) @(posedge mclk);
        num_errors++;
        tally_and_finish();
    end

    initial begin
        rstn = 1'b0;
        wr = 1'b0;
        rd = 1'b0;
        mute_n = 1'b1;
        addr = 16'h0000;
        wdata = 16'h0000;
        for (int k = 0; k < 4; k++)
            smp[k] = 16'h0000;
        num_errors = 0;
        comparisons = 0;
        void'($urandom(65626));
        repeat (3) @(posedge mclk);
        rstn <= 1'b1;
        cyc(2);
        chk("legs", {8'h00, pp, nn}, 16'h000F);
        chk("ready", 16'(rdy), 16'h0000);
        rd_reg(16'h000A, v);
        chk("misc", v, clsd_pkg::MISC_RESET);
        rd_reg(16'h001F, v);
        chk("stage", v, clsd_pkg::STG_RESET);
        wr_reg(16'h000B, 16'h0001);
        wr_reg(16'h000A, 16'h0000);
        cyc(50);
        chk("ready", 16'(rdy), 16'h0000);
        rd_reg(16'h0033, v);
        chk("unmapped", v, 16'h0000);
        wr_reg(16'h001F, 16'h0079);
        wr_reg(16'h000A, 16'h0001);
        rd_reg(16'h000A, v);
        chk("misc", v, 16'h0003);
        cyc(300);
        chk("ready", 16'(rdy), 16'h0000);
        chk("ramp", 16'(duty[0] > 0 && duty[0] < 65), 16'h0001);
        // the duty meter lags up to two frames behind the end of the ramp
        cyc(700);
        chk("ready", 16'(rdy), 16'h0001);
        for (int k = 0; k < 4; k++)
            chk("duty", 16'(duty[k]), exp_duty(16'h0000));
        for (int i = 0; i < 10; i++) begin
            @(posedge mclk);
            for (int k = 0; k < 4; k++)
                smp[k] <= (i < 4) ? CORNER[i] : 16'($urandom);
            cyc(300);
            for (int k = 0; k < 4; k++)
                chk("duty", 16'(duty[k]), exp_duty(smp[k]));
        end
        set_all(16'h4000);
        cyc(10);
        prev = pp[0];
        edges = 0;
        repeat (1300) begin
            cyc(1);
            if (pp[0] && !prev)
                edges++;
            prev = pp[0];
        end
        chk("edges", 16'(edges), 16'h000A);
        wr_reg(16'h001F, 16'h0008);
        @(posedge mclk);
        mute_n <= 1'b0;
        cyc(300);
        chk("fade", 16'(duty[0] > 65 && duty[0] < 97), 16'h0001);
        cyc(800);
        chk("muted", 16'(duty[0]), exp_duty(16'h0000));
        chk("other", 16'(duty[1]), exp_duty(16'h4000));
        rd_reg(16'h001F, v);
        chk("stage", v, 16'h0088);
        @(posedge mclk);
        mute_n <= 1'b1;
        cyc(1000);
        chk("unmuted", 16'(duty[0]), exp_duty(16'h4000));
        wr_reg(16'h001F, 16'h000A);
        @(posedge mclk);
        mute_n <= 1'b0;
        cyc(800);
        @(posedge mclk);
        mute_n <= 1'b1;
        cyc(800);
        chk("held", 16'(duty[0]), exp_duty(16'h0000));
        wr_reg(16'h001F, 16'h000E);
        cyc(1000);
        chk("released", 16'(duty[0]), exp_duty(16'h4000));
        wr_reg(16'h001F, 16'h0008);
        wr_reg(16'h000A, 16'h0000);
        cyc(2);
        chk("ready", 16'(rdy), 16'h0000);
        rd_reg(16'h000A, v);
        chk("misc", v, 16'h0002);
        cyc(1000);
        for (int k = 0; k < 4; k++)
            chk("off", 16'(duty[k]), 16'h0000);
        wr_reg(16'h000A, 16'h0001);
        cyc(2);
        chk("early", 16'(rdy), 16'h0001);
        chk("pairs", 16'(bad), 16'h0000);
        tally_and_finish();
    end
endmodule
